// [verilog/srf_pkg.sv]
// Overview of operation
// R1 - Security read: 48H, three address bytes, dummy
// R2 - Security data leaves on falling clock edges
// R3 - Byte address steps up after each byte
// R4 - Low address byte wraps FFH to 00H
// R5 - Middle byte picks one of four registers
// R6 - Chip select high ends read, output released
// R7 - Reset needs 66H frame then 99H frame
// R8 - Accepted reset clears all volatile state bits
// R9 - Commands ignored during reset recovery time
// R10 - Host checks busy and suspend before reset
// R11 - Host waits 30 us, or 12 ms after erase
// R12 - 5AH table starts with signature bytes
// R13 - Table read framed like fast read
// R14 - Header bytes 04H-07H give revisions, count
// R15 - First parameter header points to 30H
// R16 - Second parameter header points to 60H
// R17 - Bytes 30H-31H: erase size, granularity, opcode
// R18 - Byte 32H lists fast read modes
// R19 - Bytes 38H-3BH: quad read wait, opcodes
// R20 - Bytes 3CH-3FH: dual read wait, opcodes
// R21 - All-dual and all-quad reads marked unsupported
// R22 - Bytes 4CH-53H: erase types and opcodes
// R23 - Vendor bytes 64H-67H: reset, suspend, wrap
// R24 - Vendor bytes 68H-6BH: locking features
package srf_pkg;
  // Command opcodes
  localparam logic [7:0] OP_SECREG_READ = 8'h48;
  localparam logic [7:0] OP_PARAM_READ = 8'h5A;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  // Frame layout
  localparam int CMD_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int DUMMY_BITS = 8;
  localparam logic [3:0] ONLY_OPCODE_BITS = 4'h8;
  localparam logic [7:0] SECREG_SEL_MAX = 8'h03;
  localparam logic [7:0] BYTE_BLANK = 8'hFF;
  localparam int SEC_BYTES = 1024;
  // Identity byte of the second header, value arbitrary
  localparam logic [7:0] MFR_ID_BYTE = 8'h3C;
  // Volatile state widths
  localparam int RDPARAM_W = 8;
  localparam int CRM_W = 8;
  localparam int WRAP_W = 3;
  localparam int VOL_W = 2 + RDPARAM_W + CRM_W + WRAP_W;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int T_RST_US = 30;
  localparam int T_RST_E_MS = 12;
  localparam int RST_CYC = T_RST_US * (CLK_HZ / 1_000_000);
  localparam int RST_E_CYC = T_RST_E_MS * (CLK_HZ / 1_000);
  localparam int DEV_RST_MARGIN = 8;
  localparam int DEV_RST_CYC = RST_CYC - DEV_RST_MARGIN;
  localparam int WAIT_W = 17;
  localparam int SCK_HALF = 8;
  // Host register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam int CTRL_ADDR_BIT = 8;
  localparam int CTRL_NB_LSB = 9;
  localparam int CTRL_RD_BIT = 11;
  localparam int CTRL_LONG_BIT = 12;
  localparam int CTRL_GUARD_BIT = 13;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
endpackage : srf_pkg

// [verilog/srf_link_if.sv]
`timescale 1ns/1ps
interface srf_link_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;
  // Released data line floats high
  assign so_line = so_oe ? so : 1'b1;
  modport dev (input cs_n, input sclk, input si, output so, output so_oe);
  modport host (output cs_n, output sclk, output si, input so_line);
endinterface : srf_link_if

// [verilog/srf_sync.sv]
`timescale 1ns/1ps
module srf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Two-stage synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : srf_sync

// [verilog/srf_dev.sv]
`timescale 1ns/1ps
module srf_dev
  import srf_pkg::*;
#(
  parameter int RST_E_CYC_P = RST_E_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  srf_link_if.dev link,
  input wire logic sec_wr_en,
  input wire logic [9:0] sec_wr_addr,
  input wire logic [7:0] sec_wr_data,
  input wire logic vol_load,
  input wire logic [VOL_W-1:0] vol_in,
  input wire logic erase_active,
  output logic [VOL_W-1:0] vol_q,
  output logic sw_reset_q,
  output logic recovering_q
);
  typedef enum logic [2:0] {
    S_IDLE, S_CMD, S_ADDR, S_DUMMY, S_DATA, S_SKIP, S_RECOVER
  } srf_dev_state_t;

  srf_dev_state_t state_q, state_d;
  logic [2:0] pin_s;
  logic cs_s, sclk_s, si_s;
  logic cs_prev_q, sclk_prev_q;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  logic [7:0] sh_q, sh_d, op_q, op_d;
  logic [23:0] addr_q, addr_d;
  logic [4:0] cnt_q, cnt_d;
  logic [3:0] nbits_q, nbits_d;
  logic rst_en_q, rst_en_d;
  logic so_q, so_d, oe_q, oe_d;
  logic [VOL_W-1:0] vol_d;
  logic sw_reset_d, recovering_d;
  logic [WAIT_W-1:0] rcnt_q, rcnt_d;
  logic [7:0] cur_byte;
  logic [7:0] sec_mem [SEC_BYTES];
  logic in_frame;

  // Table contents served by the parameter read
  function automatic logic [7:0] param_byte(input logic [7:0] a);
    logic [7:0] b;
    b = BYTE_BLANK;
    case (a)
      8'h00: b = 8'h53; // R12
      8'h01: b = 8'h46;
      8'h02: b = 8'h44;
      8'h03: b = 8'h50;
      8'h04, 8'h08, 8'h09, 8'h0D, 8'h0E, 8'h11, 8'h15, 8'h16: b = 8'h00; // R14 R15 R16
      8'h05, 8'h06, 8'h0A, 8'h12: b = 8'h01; // R14 R15 R16
      8'h0B: b = 8'h09; // R15
      8'h0C: b = 8'h30;
      8'h10: b = MFR_ID_BYTE; // R16
      8'h13: b = 8'h03;
      8'h14: b = 8'h60;
      8'h30: b = 8'hE5; // R17
      8'h31: b = 8'h20;
      8'h32: b = 8'hF1; // R18
      8'h36: b = 8'h7F;
      8'h37, 8'h46, 8'h4A, 8'h52: b = 8'h00; // R21 R22
      8'h38: b = 8'h44; // R19
      8'h39: b = 8'hEB;
      8'h3A: b = 8'h08;
      8'h3B: b = 8'h6B;
      8'h3C: b = 8'h08; // R20
      8'h3D: b = 8'h3B;
      8'h3E: b = 8'h42;
      8'h3F: b = 8'hBB;
      8'h40: b = 8'hEE; // R21
      8'h4C: b = 8'h0C; // R22
      8'h4D: b = 8'h20;
      8'h4E: b = 8'h0F;
      8'h4F: b = 8'h52;
      8'h50: b = 8'h10;
      8'h51: b = 8'hD8;
      8'h60, 8'h62: b = 8'h00;
      8'h61: b = 8'h36;
      8'h63: b = 8'h27;
      8'h64: b = 8'h9E; // R23
      8'h65: b = 8'hF9;
      8'h66: b = 8'h77;
      8'h67: b = 8'h64;
      8'h68: b = 8'hFC; // R24
      8'h69: b = 8'hEB;
      default: b = BYTE_BLANK;
    endcase
    return b;
  endfunction : param_byte

  // Pins arrive from the host clock-free, resynchronise
  srf_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d({link.cs_n, link.sclk, link.si}),
    .q(pin_s)
  );

  assign cs_s = pin_s[2];
  assign sclk_s = pin_s[1];
  assign si_s = pin_s[0];
  assign sclk_rise = !cs_s && sclk_s && !sclk_prev_q;
  assign sclk_fall = !cs_s && !sclk_s && sclk_prev_q;
  assign cs_fall = !cs_s && cs_prev_q;
  assign cs_rise = cs_s && !cs_prev_q;
  assign in_frame = state_q inside {S_CMD, S_ADDR, S_DUMMY, S_DATA, S_SKIP};

  // Security register contents loaded from the user side
  always_ff @(posedge hclk) begin
    if (sec_wr_en) begin
      sec_mem[sec_wr_addr] <= sec_wr_data;
    end
  end

  // Byte under the read pointer
  always_comb begin
    cur_byte = BYTE_BLANK;
    if (op_q == OP_SECREG_READ) begin
      if (addr_q[23:16] == 8'h00 && addr_q[15:8] <= SECREG_SEL_MAX) begin // R5
        cur_byte = sec_mem[{addr_q[9:8], addr_q[7:0]}];
      end
    end else if (addr_q[23:8] == 16'h0000) begin
      cur_byte = param_byte(addr_q[7:0]); // R12
    end
  end

  // Command decoder next state
  always_comb begin
    state_d = state_q;
    sh_d = sh_q;
    op_d = op_q;
    addr_d = addr_q;
    cnt_d = cnt_q;
    nbits_d = nbits_q;
    rst_en_d = rst_en_q;
    so_d = so_q;
    oe_d = oe_q;
    vol_d = vol_q;
    sw_reset_d = 1'b0;
    rcnt_d = rcnt_q;
    if (sclk_rise && nbits_q != 4'hF) begin
      nbits_d = nbits_q + 4'h1;
    end
    if (vol_load) begin
      vol_d = vol_in;
    end
    case (state_q)
      S_IDLE: begin
        if (cs_fall) begin
          state_d = S_CMD;
          cnt_d = 5'h00;
          nbits_d = 4'h0;
        end
      end
      S_CMD: begin
        if (sclk_rise) begin // R1
          sh_d = {sh_q[6:0], si_s};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'(CMD_BITS - 1)) begin
            op_d = {sh_q[6:0], si_s};
            cnt_d = 5'h00;
            if ({sh_q[6:0], si_s} == OP_SECREG_READ || {sh_q[6:0], si_s} == OP_PARAM_READ) begin
              state_d = S_ADDR; // R13
            end else begin
              state_d = S_SKIP;
            end
          end
        end
      end
      S_ADDR: begin
        if (sclk_rise) begin // R1
          addr_d = {addr_q[22:0], si_s};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'(ADDR_BITS - 1)) begin
            state_d = S_DUMMY;
            cnt_d = 5'h00;
          end
        end
      end
      S_DUMMY: begin
        if (sclk_rise) begin // R1 R13
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'(DUMMY_BITS - 1)) begin
            state_d = S_DATA;
            cnt_d = 5'h00;
          end
        end
      end
      S_DATA: begin
        if (sclk_fall) begin // R2
          so_d = cur_byte[3'h7 - cnt_q[2:0]];
          oe_d = 1'b1;
          cnt_d = {2'h0, cnt_q[2:0] + 3'h1};
          if (cnt_q[2:0] == 3'h7) begin
            if (op_q == OP_SECREG_READ) begin
              addr_d = {addr_q[23:8], addr_q[7:0] + 8'h01}; // R3 R4
            end else begin
              addr_d = addr_q + 24'h000001; // R13
            end
          end
        end
      end
      S_RECOVER: begin
        if (rcnt_q == '0) begin // R9
          state_d = cs_s ? S_IDLE : S_SKIP;
        end else begin
          rcnt_d = rcnt_q - WAIT_W'(1);
        end
      end
      S_SKIP: begin
        state_d = S_SKIP;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    // Frame end: release output, judge reset frames
    if (cs_rise && in_frame) begin // R6
      state_d = S_IDLE;
      oe_d = 1'b0;
      so_d = 1'b1;
      rst_en_d = 1'b0;
      if (nbits_q == ONLY_OPCODE_BITS && op_q == OP_RESET_ENABLE) begin // R7
        rst_en_d = 1'b1;
      end else if (nbits_q == ONLY_OPCODE_BITS && op_q == OP_RESET && rst_en_q) begin // R7
        sw_reset_d = 1'b1; // R8
        vol_d = '0; // R8
        state_d = S_RECOVER; // R9
        rcnt_d = erase_active ? WAIT_W'(RST_E_CYC_P - DEV_RST_MARGIN) : WAIT_W'(DEV_RST_CYC);
      end
    end
  end
  assign recovering_d = (state_d == S_RECOVER);
  // Decoder registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= S_IDLE;
      cs_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
      sh_q <= 8'h00;
      op_q <= 8'h00;
      addr_q <= 24'h000000;
      cnt_q <= 5'h00;
      nbits_q <= 4'h0;
      rst_en_q <= 1'b0;
      so_q <= 1'b1;
      oe_q <= 1'b0;
      vol_q <= '0;
      sw_reset_q <= 1'b0;
      recovering_q <= 1'b0;
      rcnt_q <= '0;
    end else begin
      state_q <= state_d;
      cs_prev_q <= cs_s;
      sclk_prev_q <= sclk_s;
      sh_q <= sh_d;
      op_q <= op_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      nbits_q <= nbits_d;
      rst_en_q <= rst_en_d;
      so_q <= so_d;
      oe_q <= oe_d;
      vol_q <= vol_d;
      sw_reset_q <= sw_reset_d;
      recovering_q <= recovering_d;
      rcnt_q <= rcnt_d;
    end
  end

  assign link.so = so_q;
  assign link.so_oe = oe_q;
endmodule : srf_dev

// [verilog/srf_host.sv]
`timescale 1ns/1ps
module srf_host
  import srf_pkg::*;
#(
  parameter int RST_E_CYC_P = RST_E_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  srf_link_if.host link
);
  typedef enum logic [2:0] {H_IDLE, H_RUN, H_END, H_GAP, H_WAIT} srf_host_state_t;

  srf_host_state_t st_q, st_d;
  logic so_s;
  logic ap_q, ap_d, apw_q, apw_d;
  logic [7:0] apa_q, apa_d;
  logic [31:0] hrdata_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic [23:0] addr_q, addr_d;
  logic done_q, done_d, ref_q, ref_d;
  logic [31:0] rdata_q, rdata_d;
  logic [3:0] div_q, div_d;
  logic sclk_q, sclk_d, cs_n_q, cs_n_d, si_q, si_d;
  logic [39:0] tx_q, tx_d;
  logic [5:0] txn_q, txn_d, rxn_q, rxn_d;
  logic [4:0] rxc_q, rxc_d;
  logic [7:0] byte_q, byte_d;
  logic [WAIT_W-1:0] wcnt_q, wcnt_d;
  logic tick, wr_ctrl, wr_stat;
  logic [2:0] nbytes;
  logic [7:0] new_op;

  // Returned data comes back clock-free, resynchronise
  srf_sync #(.W(1), .RST_VAL(1'h1)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d(link.so_line),
    .q(so_s)
  );

  assign tick = (div_q == 4'(SCK_HALF - 1));
  assign wr_ctrl = ap_q && apw_q && apa_q == REG_CTRL;
  assign wr_stat = ap_q && apw_q && apa_q == REG_STATUS;
  assign new_op = hwdata[7:0];
  assign nbytes = {1'b0, hwdata[CTRL_NB_LSB+1:CTRL_NB_LSB]} + 3'h1;

  // Bus slave and frame sequencer next state
  always_comb begin
    ap_d = hsel && hready && htrans[1];
    apw_d = hwrite;
    apa_d = haddr[7:0];
    hrdata_d = hrdata;
    st_d = st_q;
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    done_d = done_q;
    ref_d = ref_q;
    rdata_d = rdata_q;
    div_d = tick ? 4'h0 : div_q + 4'h1;
    sclk_d = sclk_q;
    cs_n_d = cs_n_q;
    si_d = si_q;
    tx_d = tx_q;
    txn_d = txn_q;
    rxn_d = rxn_q;
    rxc_d = rxc_q;
    byte_d = byte_q;
    wcnt_d = wcnt_q;
    if (ap_d) begin
      case (haddr[7:0])
        REG_CTRL: hrdata_d = {16'h0000, ctrl_q};
        REG_ADDR: hrdata_d = {8'h00, addr_q};
        REG_STATUS: hrdata_d = {29'h0, ref_q, done_q, st_q != H_IDLE};
        REG_RDATA: hrdata_d = rdata_q;
        default: hrdata_d = 32'h00000000;
      endcase
    end
    // Write-one-to-clear status, later sets win
    if (wr_stat) begin
      if (hwdata[STAT_DONE_BIT]) done_d = 1'b0;
      if (hwdata[STAT_REFUSED_BIT]) ref_d = 1'b0;
    end
    if (ap_q && apw_q && apa_q == REG_ADDR && st_q == H_IDLE) begin
      addr_d = hwdata[23:0];
    end
    case (st_q)
      H_IDLE: begin
        div_d = 4'h0;
        if (wr_ctrl) begin
          if (hwdata[CTRL_GUARD_BIT] && (new_op == OP_RESET_ENABLE || new_op == OP_RESET)) begin
            ref_d = 1'b1; // R10
          end else begin
            ctrl_d = hwdata[15:0];
            tx_d = {new_op, addr_q, 8'h00}; // R1 R13
            txn_d = hwdata[CTRL_ADDR_BIT] ? 6'(CMD_BITS + ADDR_BITS + DUMMY_BITS) : 6'(CMD_BITS);
            rxn_d = hwdata[CTRL_RD_BIT] ? {nbytes, 3'h0} : 6'h00;
            rxc_d = 5'h00;
            rdata_d = 32'h00000000;
            cs_n_d = 1'b0;
            si_d = new_op[7];
            st_d = H_RUN;
          end
        end
      end
      H_RUN: begin
        if (tick && !sclk_q) begin
          sclk_d = 1'b1;
          if (txn_q != 6'h00) begin
            txn_d = txn_q - 6'h01;
          end else begin // R2
            byte_d = {byte_q[6:0], so_s};
            rxn_d = rxn_q - 6'h01;
            rxc_d = rxc_q + 5'h01;
            if (rxc_q[2:0] == 3'h7) begin
              rdata_d[{rxc_q[4:3], 3'h0} +: 8] = {byte_q[6:0], so_s};
            end
          end
        end else if (tick) begin
          sclk_d = 1'b0;
          if (txn_q != 6'h00) begin
            tx_d = {tx_q[38:0], 1'b0};
            si_d = tx_q[38];
          end else if (rxn_q == 6'h00) begin
            st_d = H_END;
          end
        end
      end
      H_END: begin
        if (tick) begin
          cs_n_d = 1'b1; // R6 R7
          st_d = H_GAP;
        end
      end
      H_GAP: begin
        if (tick) begin
          if (ctrl_q[7:0] == OP_RESET) begin // R11
            wcnt_d = ctrl_q[CTRL_LONG_BIT] ? WAIT_W'(RST_E_CYC_P) : WAIT_W'(RST_CYC);
            st_d = H_WAIT;
          end else begin
            st_d = H_IDLE;
          end
        end
      end
      H_WAIT: begin
        wcnt_d = wcnt_q - WAIT_W'(1);
        if (wcnt_q == WAIT_W'(1)) begin // R11
          st_d = H_IDLE;
        end
      end
      default: begin
        st_d = H_IDLE;
      end
    endcase
    if (wr_ctrl && st_q != H_IDLE) begin
      ref_d = 1'b1;
    end
    if (st_q != H_IDLE && st_d == H_IDLE) begin
      done_d = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= 1'b0;
      apw_q <= 1'b0;
      apa_q <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      st_q <= H_IDLE;
      ctrl_q <= CTRL_RESET;
      addr_q <= 24'h000000;
      done_q <= 1'b0;
      ref_q <= 1'b0;
      rdata_q <= 32'h00000000;
      div_q <= 4'h0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      si_q <= 1'b0;
      tx_q <= 40'h0000000000;
      txn_q <= 6'h00;
      rxn_q <= 6'h00;
      rxc_q <= 5'h00;
      byte_q <= 8'h00;
      wcnt_q <= '0;
    end else begin
      ap_q <= ap_d;
      apw_q <= apw_d;
      apa_q <= apa_d;
      hrdata <= hrdata_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      done_q <= done_d;
      ref_q <= ref_d;
      rdata_q <= rdata_d;
      div_q <= div_d;
      sclk_q <= sclk_d;
      cs_n_q <= cs_n_d;
      si_q <= si_d;
      tx_q <= tx_d;
      txn_q <= txn_d;
      rxn_q <= rxn_d;
      rxc_q <= rxc_d;
      byte_q <= byte_d;
      wcnt_q <= wcnt_d;
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.si = si_q;
endmodule : srf_host

// [test/srf_link_asserts.sv]
`timescale 1ns/1ps
module srf_link_asserts
  import srf_pkg::*;
#(
  parameter int RST_E_CYC_P = RST_E_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic sw_reset_q,
  input wire logic recovering_q,
  input wire logic [VOL_W-1:0] vol_q
);
  logic [16:0] rec_cnt_q;
  logic [16:0] rec_cnt_d;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Length of the running recovery span
  always_comb begin
    rec_cnt_d = recovering_q ? rec_cnt_q + 17'h00001 : 17'h00000;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_cnt_q <= 17'h00000;
    end else begin
      rec_cnt_q <= rec_cnt_d;
    end
  end
  a_clock_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_si_on_low: assert property ($changed(si) && !cs_n |-> !sclk)
    else $error("host data moved while clock high");
  a_so_after_fall: assert property ($changed(so) && !cs_n |-> !sclk)
    else $error("device data moved while clock high");
  a_release_on_deselect: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
    else $error("data line still driven after deselect");
  a_reset_deselected: assert property (sw_reset_q |-> cs_n)
    else $error("reset fired inside a frame");
  a_reset_clears_vol: assert property (sw_reset_q |-> ##[0:1] vol_q == '0)
    else $error("volatile state kept over reset");
  a_pulse_then_recover: assert property (sw_reset_q |=> !sw_reset_q && recovering_q)
    else $error("reset pulse or recovery start wrong");
  a_recovery_length: assert property ($fell(recovering_q) |->
    rec_cnt_q inside {[DEV_RST_CYC-1:DEV_RST_CYC+1], [RST_E_CYC_P-9:RST_E_CYC_P-7]})
    else $error("recovery span of wrong length");
  a_recovery_quiet: assert property (recovering_q |-> cs_n && !so_oe)
    else $error("link active during recovery");
  // Main scenarios reached
  c_reset: cover property (sw_reset_q);
  c_recover_end: cover property ($fell(recovering_q));
  c_data_out: cover property ($rose(so_oe));
endmodule : srf_link_asserts

// [test/secreg_read_reset_sfdp_cmds_test.sv]
`timescale 1ns/1ps
module secreg_read_reset_sfdp_cmds_test
  import srf_pkg::*;
;
  localparam int RST_E = 400;
  logic hclk;
  logic hresetn;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hrdy;
  logic hresp;
  logic sec_wr_en;
  logic [9:0] sec_wr_addr;
  logic [7:0] sec_wr_data;
  logic vol_load;
  logic [VOL_W-1:0] vol_in;
  logic erase_active;
  logic [VOL_W-1:0] vol_q;
  logic sw_reset_q;
  logic recovering_q;
  logic [31:0] r;
  logic [31:0] st;
  int errors;
  int check_count;
  // Read frames: opcode, address, bytes expected (first byte lowest)
  logic [63:0] tbl [18] = '{
    64'h480002FE_D4C3B2A1,
    64'h48040000_FFFFFFFF,
    64'h5A000000_50444653,
    64'h5A000004_FF010100,
    64'h5A000008_09010000,
    64'h5A00000C_FF000030,
    {56'h5A000010_030100, MFR_ID_BYTE},
    64'h5A000014_FF000060,
    64'h5A000030_FFF120E5,
    64'h5A000038_6B08EB44,
    64'h5A00003C_BB423B08,
    64'h5A000040_FFFFFFEE,
    64'h5A000044_FF00FFFF,
    64'h5A000048_FF00FFFF,
    64'h5A00004C_520F200C,
    64'h5A000050_FF00D810,
    64'h5A000064_6477F99E,
    64'h5A000068_FFFFEBFC
  };
  srf_link_if srf_link_if_i ();
  srf_host #(.RST_E_CYC_P(RST_E)) srf_host_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
    .hresp(hresp), .hrdata(hrdata), .link(srf_link_if_i));
  srf_dev #(.RST_E_CYC_P(RST_E)) srf_dev_i (
    .hclk(hclk), .hresetn(hresetn), .link(srf_link_if_i), .sec_wr_en(sec_wr_en),
    .sec_wr_addr(sec_wr_addr), .sec_wr_data(sec_wr_data), .vol_load(vol_load),
    .vol_in(vol_in), .erase_active(erase_active), .vol_q(vol_q),
    .sw_reset_q(sw_reset_q), .recovering_q(recovering_q));
  srf_link_asserts #(.RST_E_CYC_P(RST_E)) srf_link_asserts_i (
    .hclk(hclk), .hresetn(hresetn), .cs_n(srf_link_if_i.cs_n), .sclk(srf_link_if_i.sclk),
    .si(srf_link_if_i.si), .so(srf_link_if_i.so), .so_oe(srf_link_if_i.so_oe),
    .sw_reset_q(sw_reset_q), .recovering_q(recovering_q), .vol_q(vol_q));
  // Free-running bus clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // One single transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask : bus
  // Wait for done, keep status, clear the sticky flags
  task automatic poll();
    r = '0;
    for (int i = 0; i < 4000 && r[STAT_DONE_BIT] !== 1'b1; i++) begin
      bus(1'b0, REG_STATUS, '0);
    end
    st = r;
    chk(st[STAT_DONE_BIT], 1'b1);
    bus(1'b1, REG_STATUS, 32'h00000006);
  endtask : poll
  task automatic run(input logic [31:0] c);
    bus(1'b1, REG_CTRL, c);
    poll();
  endtask : run
  task automatic load_vol();
    vol_load <= 1'b1;
    @(posedge hclk);
    vol_load <= 1'b0;
  endtask : load_vol
  task automatic print_verdict();
    if (errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  // Hang guard
  initial begin
    #(60000 * 100);
    errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    hresetn = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = '0;
    sec_wr_en = 1'b0;
    sec_wr_addr = '0;
    sec_wr_data = '0;
    vol_load = 1'b0;
    vol_in = {VOL_W{1'b1}};
    erase_active = 1'b0;
    errors = 0;
    check_count = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, REG_CTRL, '0);
    chk(r, {16'h0000, CTRL_RESET});
    bus(1'b0, REG_STATUS, '0);
    chk(r, 32'h00000000);
    chk({srf_link_if_i.cs_n, srf_link_if_i.sclk, srf_link_if_i.so_oe}, 3'b100);
    chk(hresp, 1'b0);
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    bus(1'b0, 8'h40, '0);
    chk(r, 32'h00000000);
    // Four bytes wrapping from the end of register 2 back to its start
    for (int k = 0; k < 4; k++) begin
      sec_wr_en <= 1'b1;
      sec_wr_addr <= {2'b10, 8'hFE + 8'(k)};
      sec_wr_data <= 8'hA1 + 8'(k * 17);
      @(posedge hclk);
    end
    sec_wr_en <= 1'b0;
    foreach (tbl[i]) begin
      bus(1'b1, REG_ADDR, {8'h00, tbl[i][55:32]});
      run({20'h00000, 4'hF, tbl[i][63:56]});
      bus(1'b0, REG_RDATA, '0);
      chk(r, tbl[i][31:0]);
    end
    // Orders while a frame runs are dropped
    bus(1'b1, REG_ADDR, 32'h00000000);
    bus(1'b1, REG_CTRL, 32'h00000F5A);
    bus(1'b1, REG_CTRL, 32'h00000F48);
    bus(1'b1, REG_ADDR, 32'h00000004);
    poll();
    chk(st[STAT_REFUSED_BIT], 1'b1);
    bus(1'b1, REG_RDATA, 32'h00000000);
    bus(1'b0, REG_RDATA, '0);
    chk(r, 32'h50444653);
    bus(1'b0, REG_ADDR, '0);
    chk(r, 32'h00000000);
    // Two-byte read of the first header pointer
    bus(1'b1, REG_ADDR, 32'h0000000C);
    run(32'h00000B5A);
    bus(1'b0, REG_RDATA, '0);
    chk(r, 32'h00000030);
    // Broken reset sequence keeps volatile state
    load_vol();
    run(32'h00000066);
    run(32'h00000005);
    run(32'h00000099);
    chk(vol_q, {VOL_W{1'b1}});
    run(32'h00000066);
    run(32'h00000099);
    chk(vol_q, '0);
    // Guarded reset enable is refused at once
    bus(1'b1, REG_CTRL, 32'h00002066);
    bus(1'b0, REG_STATUS, '0);
    bus(1'b0, REG_STATUS, '0);
    chk({r[STAT_BUSY_BIT], r[STAT_REFUSED_BIT]}, 2'b01);
    bus(1'b1, REG_STATUS, 32'h00000006);
    // Reset over an erase takes the long recovery
    erase_active <= 1'b1;
    load_vol();
    run(32'h00000066);
    bus(1'b1, REG_CTRL, 32'h00001099);
    bus(1'b1, REG_CTRL, 32'h00000F5A);
    poll();
    chk(st[STAT_REFUSED_BIT], 1'b1);
    chk(vol_q, '0);
    erase_active <= 1'b0;
    bus(1'b1, REG_ADDR, 32'h00000000);
    run(32'h00000F5A);
    bus(1'b0, REG_RDATA, '0);
    chk(r, 32'h50444653);
    print_verdict();
  end
endmodule : secreg_read_reset_sfdp_cmds_test
